// File: logic/csf_pkg.sv
package csf_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned NUM_ALARMS = 2048;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_FLAGS = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ALARM = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_NET_CODE = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_RMT_CODE = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 8'h14;

  localparam int unsigned FLAG_W = 16;
  localparam int unsigned EVT_W = 5;

  // Flag word layout, highest bit first in declaration order
  typedef struct packed {
    logic [5:0] unused;
    logic serial_tx_idle;
    logic serial_rx_done;
    logic serial_comm_error;
    logic remote_rw_fault;
    logic remote_rw_ready;
    logic run_edit_active;
    logic print_instr_active;
    logic serial_port_mode;
    logic network_send_recv_fault;
    logic network_send_recv_ready;
  } csf_flags_s;

  // Sticky event layout
  typedef struct packed {
    logic alarm_rise;
    logic serial_rx_done;
    logic serial_comm_error;
    logic remote_rw_fault;
    logic network_send_recv_fault;
  } csf_events_s;

  localparam csf_flags_s FLAGS_RESET = '{
    unused: 6'h00,
    serial_tx_idle: 1'b1,
    default: 1'b0
  };
  localparam logic [EVT_W-1:0] EVT_RESET = 5'h00;
  localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // Serial port mode encoding
  localparam logic MODE_GENERAL = 1'b1;
  localparam logic MODE_HOST_LINK = 1'b0;

endpackage

// File: logic/csf_flag_bank.sv
`timescale 1ns/10ps
module csf_flag_bank #(
  parameter int unsigned NUM_ALARMS = csf_pkg::NUM_ALARMS,
  parameter int unsigned CODE_W = csf_pkg::CODE_W
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  // Register port
  input wire logic [csf_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [csf_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [csf_pkg::DATA_W-1:0] O_RDATA,
  output logic O_IRQ,
  // Network send/receive instruction status
  input wire logic I_NET_READY,
  input wire logic I_NET_START,
  input wire logic I_NET_ERR,
  input wire logic [CODE_W-1:0] I_NET_ERR_CODE,
  // Remote memory read/write instruction status
  input wire logic I_RMT_READY,
  input wire logic I_RMT_START,
  input wire logic I_RMT_ERR,
  input wire logic [CODE_W-1:0] I_RMT_ERR_CODE,
  // Serial port status
  input wire logic I_SER_MODE,
  input wire logic I_SER_ERR,
  input wire logic I_SER_TX_START,
  input wire logic I_SER_TX_BUSY,
  input wire logic I_SER_RX_END,
  // Printer output and run-mode editing
  input wire logic I_PRINT_BUSY,
  input wire logic I_RUN_EDIT,
  // Error alarm relays
  input wire logic [NUM_ALARMS-1:0] I_ALARM_RELAYS,
  // Flag bank to the program scan
  output csf_pkg::csf_flags_s O_FLAGS,
  output logic O_ALARM_SUMMARY
);

  csf_pkg::csf_flags_s flags_word;
  logic net_ready_q;
  logic net_fault_q;
  logic ser_mode_q;
  logic print_q;
  logic edit_q;
  logic rmt_ready_q;
  logic rmt_fault_q;
  logic ser_err_q;
  logic rx_done_q;
  logic tx_idle_q;
  logic [5:0] unused_q;
  logic [csf_pkg::EVT_W-1:0] evt_clr;
  logic [csf_pkg::EVT_W-1:0] evt_status_d;
  logic [csf_pkg::DATA_W-1:0] rdata_d;
  logic irq_d;
  logic alarm_q;
  logic [CODE_W-1:0] net_code_q;
  logic [CODE_W-1:0] rmt_code_q;
  logic [csf_pkg::EVT_W-1:0] evt_status_q;
  logic [csf_pkg::EVT_W-1:0] evt_mask_q;
  logic [csf_pkg::DATA_W-1:0] rdata_q;
  logic irq_q;
  csf_pkg::csf_events_s evt_raw;
  logic alarm_d;
  logic ser_general;

  function automatic logic [csf_pkg::DATA_W-1:0] zext_code(input logic [CODE_W-1:0] code);
    zext_code = csf_pkg::RDATA_ZERO;
    zext_code[CODE_W-1:0] = code;
  endfunction

  function automatic logic reg_hit(input logic [csf_pkg::ADDR_W-1:0] a,
                                   input logic [csf_pkg::ADDR_W-1:0] target);
    reg_hit = (a == target);
  endfunction

  assign ser_general = (I_SER_MODE == csf_pkg::MODE_GENERAL);

  assign alarm_d = |I_ALARM_RELAYS;

  always_comb begin
    evt_raw = '0;
    evt_raw.network_send_recv_fault = I_NET_ERR;
    evt_raw.remote_rw_fault = I_RMT_ERR;
    evt_raw.serial_comm_error = I_SER_ERR && ser_general;
    evt_raw.serial_rx_done = I_SER_RX_END && ser_general;
    evt_raw.alarm_rise = alarm_d && !alarm_q;
  end

  // Level flags, one register each so every flag has a single driver
  // net ready
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      net_ready_q <= csf_pkg::FLAGS_RESET.network_send_recv_ready;
    end else begin
      net_ready_q <= I_NET_READY;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ser_mode_q <= csf_pkg::MODE_HOST_LINK;
    end else begin
      ser_mode_q <= I_SER_MODE;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      print_q <= csf_pkg::FLAGS_RESET.print_instr_active;
    end else begin
      print_q <= I_PRINT_BUSY;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      edit_q <= csf_pkg::FLAGS_RESET.run_edit_active;
    end else begin
      edit_q <= I_RUN_EDIT;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rmt_ready_q <= csf_pkg::FLAGS_RESET.remote_rw_ready;
    end else begin
      rmt_ready_q <= I_RMT_READY;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      tx_idle_q <= csf_pkg::FLAGS_RESET.serial_tx_idle;
    end else begin
      tx_idle_q <= !I_SER_TX_BUSY;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      unused_q <= csf_pkg::FLAGS_RESET.unused;
    end else begin
      unused_q <= csf_pkg::FLAGS_RESET.unused;
    end
  end

  // Network fault: a new instruction start clears, an error in the same cycle wins
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      net_fault_q <= csf_pkg::FLAGS_RESET.network_send_recv_fault;
      net_code_q <= csf_pkg::CODE_RESET;
    end else begin
      if (I_NET_ERR) begin
        net_fault_q <= 1'b1;
        net_code_q <= I_NET_ERR_CODE;
      end else if (I_NET_START) begin
        net_fault_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rmt_fault_q <= csf_pkg::FLAGS_RESET.remote_rw_fault;
      rmt_code_q <= csf_pkg::CODE_RESET;
    end else begin
      if (I_RMT_ERR) begin
        rmt_fault_q <= 1'b1;
        rmt_code_q <= I_RMT_ERR_CODE;
      end else if (I_RMT_START) begin
        rmt_fault_q <= 1'b0;
      end
    end
  end

  // Error beats a transmit start in the same cycle so it is not lost
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      ser_err_q <= csf_pkg::FLAGS_RESET.serial_comm_error;
    end else begin
      if (evt_raw.serial_comm_error) begin
        ser_err_q <= 1'b1;
      end else if (I_SER_TX_START) begin
        ser_err_q <= 1'b0;
      end
    end
  end

  // Receive-done is rearmed by the next transmit start
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rx_done_q <= csf_pkg::FLAGS_RESET.serial_rx_done;
    end else begin
      if (evt_raw.serial_rx_done) begin
        rx_done_q <= 1'b1;
      end else if (I_SER_TX_START) begin
        rx_done_q <= 1'b0;
      end
    end
  end

  // Flag word is wiring only, so the output still comes from registers
  always_comb begin
    flags_word = csf_pkg::FLAGS_RESET;
    flags_word.network_send_recv_ready = net_ready_q;
    flags_word.network_send_recv_fault = net_fault_q;
    flags_word.serial_port_mode = ser_mode_q;
    flags_word.print_instr_active = print_q;
    flags_word.run_edit_active = edit_q;
    flags_word.remote_rw_ready = rmt_ready_q;
    flags_word.remote_rw_fault = rmt_fault_q;
    flags_word.serial_comm_error = ser_err_q;
    flags_word.serial_rx_done = rx_done_q;
    flags_word.serial_tx_idle = tx_idle_q;
    flags_word.unused = unused_q;
  end

  // Wide OR registered once; one cycle of lag on a 2048-input tree
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      alarm_q <= 1'b0;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  always_comb begin
    evt_clr = csf_pkg::EVT_RESET;
    if (I_WR && reg_hit(I_ADDR, csf_pkg::ADDR_EVT_STATUS)) begin
      evt_clr = I_WDATA[csf_pkg::EVT_W-1:0];
    end
    evt_status_d = (evt_status_q & ~evt_clr) | evt_raw;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      evt_status_q <= csf_pkg::EVT_RESET;
    end else begin
      evt_status_q <= evt_status_d;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      evt_mask_q <= csf_pkg::EVT_RESET;
    end else if (I_WR && reg_hit(I_ADDR, csf_pkg::ADDR_EVT_MASK)) begin
      evt_mask_q <= I_WDATA[csf_pkg::EVT_W-1:0];
    end
  end

  // Raw events included so the interrupt is not a further cycle late
  assign irq_d = |((evt_status_q | evt_raw) & evt_mask_q);

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_d = csf_pkg::RDATA_ZERO;
    if (I_RD) begin
      case (I_ADDR)
        csf_pkg::ADDR_FLAGS: begin
          rdata_d = {{(csf_pkg::DATA_W - csf_pkg::FLAG_W){1'b0}}, flags_word};
        end
        csf_pkg::ADDR_ALARM: begin
          rdata_d = {{(csf_pkg::DATA_W - 1){1'b0}}, alarm_q};
        end
        csf_pkg::ADDR_NET_CODE: begin
          rdata_d = zext_code(net_code_q);
        end
        csf_pkg::ADDR_RMT_CODE: begin
          rdata_d = zext_code(rmt_code_q);
        end
        csf_pkg::ADDR_EVT_STATUS: begin
          rdata_d = {{(csf_pkg::DATA_W - csf_pkg::EVT_W){1'b0}}, evt_status_q};
        end
        csf_pkg::ADDR_EVT_MASK: begin
          rdata_d = {{(csf_pkg::DATA_W - csf_pkg::EVT_W){1'b0}}, evt_mask_q};
        end
        default: begin
          rdata_d = csf_pkg::RDATA_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rdata_q <= csf_pkg::RDATA_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign O_RDATA = rdata_q;
  assign O_IRQ = irq_q;
  assign O_FLAGS = flags_word;
  assign O_ALARM_SUMMARY = alarm_q;

endmodule

// File: testbench/csf_flag_bank_sva.sv
`timescale 1ns/10ps
module csf_flag_bank_sva #(
  parameter int unsigned NUM_ALARMS = 2048
) (
  input wire logic I_SYS_CLK,
  input wire logic I_RESETN,
  input wire logic [csf_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic I_RD,
  input wire logic [csf_pkg::DATA_W-1:0] O_RDATA,
  input wire logic I_NET_READY,
  input wire logic I_NET_ERR,
  input wire logic I_RMT_ERR,
  input wire logic I_SER_MODE,
  input wire logic I_SER_ERR,
  input wire logic I_SER_TX_START,
  input wire logic I_SER_TX_BUSY,
  input wire logic I_SER_RX_END,
  input wire logic I_PRINT_BUSY,
  input wire logic [NUM_ALARMS-1:0] I_ALARM_RELAYS,
  input wire csf_pkg::csf_flags_s O_FLAGS,
  input wire logic O_ALARM_SUMMARY
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  // Past values are meaningless until one edge after reset
  logic up_q;
  always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
    if (!I_RESETN) up_q <= 1'b0;
    else up_q <= 1'b1;
  end
  sequence flags_read;
    I_RD && I_ADDR == csf_pkg::ADDR_FLAGS;
  endsequence
  a_net_ready: assert property (up_q |-> O_FLAGS.network_send_recv_ready == $past(I_NET_READY))
    else $error("net ready flag wrong");
  a_net_fault: assert property (I_NET_ERR |=> O_FLAGS.network_send_recv_fault)
    else $error("net fault not set");
  a_print_flag: assert property (up_q |-> O_FLAGS.print_instr_active == $past(I_PRINT_BUSY))
    else $error("print flag wrong");
  a_rmt_fault: assert property (I_RMT_ERR |=> O_FLAGS.remote_rw_fault)
    else $error("remote fault not set");
  a_ser_err_set: assert property (I_SER_ERR && I_SER_MODE |=> O_FLAGS.serial_comm_error)
    else $error("serial error not set");
  a_ser_err_clr: assert property (I_SER_TX_START && !(I_SER_ERR && I_SER_MODE) |=>
    !O_FLAGS.serial_comm_error) else $error("serial error not cleared");
  a_rx_done_set: assert property (I_SER_RX_END && I_SER_MODE |=> O_FLAGS.serial_rx_done)
    else $error("rx done not set");
  a_tx_idle: assert property (up_q |-> O_FLAGS.serial_tx_idle == !$past(I_SER_TX_BUSY))
    else $error("tx idle wrong");
  a_alarm_sum: assert property (up_q |-> O_ALARM_SUMMARY == $past(|I_ALARM_RELAYS))
    else $error("alarm summary wrong");
  a_unused_zero: assert property (O_FLAGS.unused == 6'h00)
    else $error("unused flags set");
  a_flag_rdback: assert property (flags_read |=> O_RDATA == {16'h0000, $past(O_FLAGS)})
    else $error("flag readback wrong");
endmodule
bind csf_flag_bank csf_flag_bank_sva #(.NUM_ALARMS(NUM_ALARMS)) sva_u (.*);

// File: testbench/csf_flag_bank_tb_top.sv
`timescale 1ns/10ps
module csf_flag_bank_tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, irq, asum;
  logic [7:0] addr = 8'h00, al = 8'h00;
  logic [31:0] wd = 32'h0, rdat, d, e;
  logic nr = 0, ns = 0, ne = 0, rr = 0, rs = 0, re = 0;
  logic sm = 0, se = 0, st = 0, sb = 0, sx = 0, pb = 0, ed = 0;
  logic [15:0] nc = 16'h0, rc = 16'h0;
  csf_pkg::csf_flags_s fl, ex;
  int errors = 0, checks = 0;
  always #2.5 clk = ~clk;
  csf_flag_bank #(.NUM_ALARMS(8)) dut_u (.I_SYS_CLK(clk), .I_RESETN(rst_n), .I_ADDR(addr),
    .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .O_IRQ(irq), .I_NET_READY(nr),
    .I_NET_START(ns), .I_NET_ERR(ne), .I_NET_ERR_CODE(nc), .I_RMT_READY(rr),
    .I_RMT_START(rs), .I_RMT_ERR(re), .I_RMT_ERR_CODE(rc), .I_SER_MODE(sm), .I_SER_ERR(se),
    .I_SER_TX_START(st), .I_SER_TX_BUSY(sb), .I_SER_RX_END(sx), .I_PRINT_BUSY(pb),
    .I_RUN_EDIT(ed), .I_ALARM_RELAYS(al), .O_FLAGS(fl), .O_ALARM_SUMMARY(asum));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge clk);
    #1;
  endtask
  task wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1; addr <= a; wd <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    rd <= 1'b1; addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdat;
  endtask
  task t_levels;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      nr <= i[0]; rr <= !i[0]; sm <= i[0]; pb <= !i[0]; ed <= i[0]; sb <= i[0];
      tick;
      ex = '0;
      ex.network_send_recv_ready = i[0]; ex.remote_rw_ready = !i[0];
      ex.serial_port_mode = i[0]; ex.print_instr_active = !i[0];
      ex.run_edit_active = i[0]; ex.serial_tx_idle = !i[0];
      chk({16'h0, fl}, {16'h0, ex});
    end
  endtask
  task t_faults;
    @(posedge clk);
    ne <= 1'b1; nc <= 16'h1234; re <= 1'b1; rc <= 16'hbeef;
    @(posedge clk);
    ne <= 1'b0; re <= 1'b0;
    #1;
    chk({fl.network_send_recv_fault, fl.remote_rw_fault}, 32'h3);
    rd_reg(csf_pkg::ADDR_NET_CODE, d);
    chk(d, 32'h1234);
    rd_reg(csf_pkg::ADDR_RMT_CODE, d);
    chk(d, 32'hbeef);
    @(posedge clk);
    ns <= 1'b1; rs <= 1'b1;
    @(posedge clk);
    ns <= 1'b0; rs <= 1'b0;
    #1;
    chk({fl.network_send_recv_fault, fl.remote_rw_fault}, 32'h0);
  endtask
  task t_serial;
    for (int m = 0; m < 2; m++) begin
      // Host link mode must ignore both events
      @(posedge clk);
      sm <= m[0]; se <= 1'b1; sx <= 1'b1;
      @(posedge clk);
      se <= 1'b0; sx <= 1'b0;
      #1;
      chk({fl.serial_comm_error, fl.serial_rx_done}, m ? 32'h3 : 32'h0);
    end
    @(posedge clk);
    st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    #1;
    chk(fl.serial_comm_error, 32'h0);
  endtask
  task t_alarm;
    wr_reg(csf_pkg::ADDR_EVT_MASK, 32'h10);
    @(posedge clk);
    al <= 8'h80;
    tick;
    chk(asum, 32'h1);
    tick;
    chk(irq, 32'h1);
    @(posedge clk);
    al <= 8'h00;
    tick;
    chk(asum, 32'h0);
    wr_reg(csf_pkg::ADDR_EVT_MASK, 32'h0);
    tick;
    chk(irq, 32'h0);
    wr_reg(csf_pkg::ADDR_EVT_STATUS, 32'h1f);
    rd_reg(csf_pkg::ADDR_EVT_STATUS, d);
    chk(d, 32'h0);
    rd_reg(8'h20, d);
    chk(d, 32'h0);
  endtask
  task t_readonly;
    rd_reg(csf_pkg::ADDR_FLAGS, d);
    chk(d, {16'h0, fl});
    wr_reg(csf_pkg::ADDR_FLAGS, 32'hffff);
    wr_reg(csf_pkg::ADDR_ALARM, 32'h1);
    rd_reg(csf_pkg::ADDR_FLAGS, e);
    chk(e, d);
  endtask
  task report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    @(posedge clk);
    #1;
    chk({16'h0, fl}, {16'h0, csf_pkg::FLAGS_RESET});
    @(posedge clk);
    rst_n <= 1'b1;
    t_levels;
    t_faults;
    t_serial;
    t_alarm;
    t_readonly;
    report_and_stop;
  end
  initial begin
    #20000;
    errors++;
    report_and_stop;
  end
endmodule
